// ### hw/aserc_consts.svh
`ifndef ASERC_CONSTS_SVH
`define ASERC_CONSTS_SVH

// register byte offsets on the control bus
`define ASERC_OFS_CTRL 4'h0
`define ASERC_OFS_CWSEL 4'h4
`define ASERC_OFS_STAT 4'h8

// reset values
`define ASERC_CTRL_RST 11'h000
`define ASERC_CWSEL_RST 32'hffff_ffff

// field positions of the control word
`define ASERC_CTRL_W 11
`define ASERC_CTRL_MSB_FIRST 0
`define ASERC_CTRL_TWOS 1
`define ASERC_CTRL_SDR 2
`define ASERC_CTRL_PIN_PART 3
`define ASERC_CTRL_FULL_PD 4
`define ASERC_CTRL_PGA_LSB 5
`define ASERC_CTRL_LPF 7
`define ASERC_CTRL_CLAMP_LSB 8

// status word field positions
`define ASERC_STAT_AWAKE 0
`define ASERC_STAT_PWR_LSB 1
`define ASERC_STAT_LOCKED 3
`define ASERC_STAT_LOST 4

// axi answers
`define ASERC_RESP_OKAY 2'h0
`define ASERC_RESP_SLVERR 2'h2

// geometry
`define ASERC_NCH 8
`define ASERC_NBITS 12
`define ASERC_NCOL 10
`define ASERC_FRAME_CYC 24

// timing: system clock and wake-up limits
`define ASERC_CLK_HZ 10000000
`define ASERC_T_WAKE_FULL_US 50
`define ASERC_T_WAKE_PART_US 2
`define ASERC_WAKE_FULL_CYC \
	(`ASERC_T_WAKE_FULL_US * (`ASERC_CLK_HZ / 1000000))
`define ASERC_WAKE_PART_CYC \
	(`ASERC_T_WAKE_PART_US * (`ASERC_CLK_HZ / 1000000))
`define ASERC_PER_MAX 8'hff

`endif

// ### hw/aserc_pkg.sv
package aserc_pkg;

	typedef enum logic [1:0] {
		ASERC_PGA_20DB,
		ASERC_PGA_25DB,
		ASERC_PGA_27DB,
		ASERC_PGA_30DB
	} aserc_pga_t;

	typedef enum logic {
		ASERC_LPF_10MHZ,
		ASERC_LPF_15MHZ
	} aserc_lpf_t;

	typedef enum logic [1:0] {
		ASERC_PWR_ON,
		ASERC_PWR_FULL_PD,
		ASERC_PWR_PART_PD,
		ASERC_PWR_WAKE
	} aserc_pwr_t;

	// control word, bit 10 first
	typedef struct packed {
		logic [2:0] clamp_level;
		aserc_lpf_t lpf_corner;
		aserc_pga_t pga_gain;
		logic full_pd;
		logic pin_partial;
		logic single_rate_select;
		logic twos_complement_select;
		logic msb_first;
	} aserc_ctrl_t;

	typedef struct packed {
		logic clk_lost;
		logic locked;
		aserc_pwr_t pwr;
		logic awake;
	} aserc_stat_t;

	typedef logic [7:0][11:0] aserc_words_t;

endpackage : aserc_pkg

// ### hw/aserc_serializer.sv
`timescale 1ns/1ns
`include "aserc_consts.svh"

module aserc_serializer
	import aserc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic load_i,
	input wire logic shift_i,
	input wire logic clear_i,
	input wire logic msb_first_i,
	input wire aserc_words_t words_i,
	output logic [`ASERC_NCH-1:0] serial_o
);

	function automatic logic [11:0] aserc_rev(input logic [11:0] w);
		logic [11:0] r;
		r = '0;
		for (int i = 0; i < `ASERC_NBITS; i++) begin
			r[i] = w[`ASERC_NBITS-1-i];
		end
		return r;
	endfunction : aserc_rev

	////////////////////////////////////////////////////////////////////
	// one shift lane per channel, all loaded on the same frame start
	for (genvar c = 0; c < `ASERC_NCH; c++) begin : g_lane
		logic [11:0] ord;
		logic [11:0] sh_q;
		// lsb leaves first unless reversed
		assign ord = msb_first_i ? aserc_rev(words_i[c]) : words_i[c]; // RULE1 RULE2
		always_ff @(posedge clk_sys_i) begin
			if (srst_i || clear_i) begin
				sh_q <= '0;
				serial_o[c] <= 1'b0;
			end else if (load_i) begin
				serial_o[c] <= ord[0]; // RULE6
				sh_q <= {1'b0, ord[11:1]};
			end else if (shift_i) begin
				serial_o[c] <= sh_q[0]; // RULE6
				sh_q <= {1'b0, sh_q[11:1]};
			end
		end
	end

endmodule : aserc_serializer

// ### hw/aserc_axil_slave.sv
`timescale 1ns/1ns
`include "aserc_consts.svh"

module aserc_axil_slave
	import aserc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire aserc_stat_t stat_i,
	output aserc_ctrl_t ctrl_o,
	output logic [31:0] cwsel_o
);

	logic aw_have, w_have;
	logic [3:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic [31:0] ctrl_word, ctrl_merge, wmask, rd_word;
	logic do_wr, wr_ctrl, wr_cw, wr_ok, rd_ok;

	////////////////////////////////////////////////////////////////////
	// write side: address and data taken in either order; the readies
	// live in flops, so a held word is simply a ready that is low
	assign aw_have = ~s_axi_awready;
	assign w_have = ~s_axi_wready;
	assign do_wr = aw_have && w_have && !s_axi_bvalid;
	assign wr_ctrl = do_wr && aw_q == `ASERC_OFS_CTRL;
	assign wr_cw = do_wr && aw_q == `ASERC_OFS_CWSEL;
	// status is read only, so a write there is refused too
	assign wr_ok = wr_ctrl || wr_cw;
	assign ctrl_word = {21'h0, ctrl_o};
	assign ctrl_merge = (ctrl_word & ~wmask) | (wd_q & wmask);
	for (genvar b = 0; b < 4; b++) begin : g_mask
		assign wmask[8*b+7:8*b] = {8{ws_q[b]}};
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ASERC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (do_wr) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `ASERC_RESP_OKAY : `ASERC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// byte-lane merge into the two writable registers
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ctrl_o <= `ASERC_CTRL_RST;
			cwsel_o <= `ASERC_CWSEL_RST;
		end else begin
			if (wr_ctrl) begin
				// bits above the control word are dropped, so read zero
				ctrl_o <= aserc_ctrl_t'(ctrl_merge[`ASERC_CTRL_W-1:0]);
			end
			if (wr_cw) begin
				cwsel_o <= (cwsel_o & ~wmask) | (wd_q & wmask);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read side: one read at a time, answer one cycle after address;
	// arready is the inverse of rvalid, held in its own flop
	assign rd_ok = s_axi_araddr == `ASERC_OFS_CTRL ||
		s_axi_araddr == `ASERC_OFS_CWSEL || s_axi_araddr == `ASERC_OFS_STAT;
	assign rd_word = s_axi_araddr == `ASERC_OFS_CTRL ? ctrl_word :
		s_axi_araddr == `ASERC_OFS_CWSEL ? cwsel_o :
		s_axi_araddr == `ASERC_OFS_STAT ? {27'h0, stat_i} : 32'h0;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `ASERC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? `ASERC_RESP_OKAY : `ASERC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : aserc_axil_slave

// ### hw/aserc_top.sv
// Operation
// RULE1: by default lsb goes out first after the frame clock rises
// RULE2: msb-first option reverses bit order, msb first after frame rise
// RULE3: wake from complete power-down finishes within 50 us
// RULE4: wake from partial power-down within 2 us if sample clock kept running
// RULE5: a control bit assigns the sleep pin to partial power-down
// RULE6: each channel's 12 result bits go out serially on its own lane
// RULE7: serializer timing locks to the sample clock, twelve bits per frame
// RULE8: bit clock at 6x and frame clock at 1x go out beside the data
// RULE9: every channel captures on the one shared sample clock edge
// RULE10: post-gain selectable among 20, 25, 27 and 30 dB
// RULE11: filter corner 10 or 15 MHz, one setting for all channels
// RULE12: clamp level programmable from the control register
// RULE13: 8x10 continuous-wave switch matrix set from a register
// RULE14: offset binary by default, twos-complement select inverts the msb
// RULE15: single-rate mode doubles the bit clock, one edge marks data
// RULE16: receiver aligns words to frame rise, one bit per clock edge
`timescale 1ns/1ns
`include "aserc_consts.svh"

module aserc_top
	import aserc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sample_clock_in_i,
	input wire logic converter_sleep_pin_i,
	input wire aserc_words_t conv_data_i,
	output logic [`ASERC_NCH-1:0] serial_data_o,
	output logic bit_clock_out_o,
	output logic frame_clock_out_o,
	output aserc_pga_t pga_gain_o,
	output aserc_lpf_t lpf_corner_o,
	output logic [2:0] clamp_level_o,
	output logic [`ASERC_NCH*`ASERC_NCOL-1:0] cw_switch_o,
	output logic power_full_o,
	output logic power_part_o,
	output logic awake_o
);

	aserc_ctrl_t ctrl;
	logic [31:0] cwsel;
	aserc_stat_t stat;

	////////////////////////////////////////////////////////////////////
	// register bus
	aserc_axil_slave u_regs (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.stat_i(stat),
		.ctrl_o(ctrl),
		.cwsel_o(cwsel)
	);

	////////////////////////////////////////////////////////////////////
	// pin synchronisers; third stage only feeds the edge detector
	logic smp_s1_q, smp_s2_q, smp_s3_q;
	logic pin_s1_q, pin_s2_q;
	logic smp_rise;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			smp_s1_q <= 1'b0;
			smp_s2_q <= 1'b0;
			smp_s3_q <= 1'b0;
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			smp_s1_q <= sample_clock_in_i;
			smp_s2_q <= smp_s1_q;
			smp_s3_q <= smp_s2_q;
			pin_s1_q <= converter_sleep_pin_i;
			pin_s2_q <= pin_s1_q;
		end
	end

	assign smp_rise = smp_s2_q && !smp_s3_q;

	////////////////////////////////////////////////////////////////////
	// lock monitor: stands in for the multiplier; lock needs two edges
	// in a row within the watchdog span, a stalled clock drops it
	logic [7:0] per_cnt_q;
	logic seen_q, locked_q, lost_q;
	logic per_timeout;

	assign per_timeout = per_cnt_q == `ASERC_PER_MAX;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			per_cnt_q <= '0;
			seen_q <= 1'b0;
			locked_q <= 1'b0;
			lost_q <= 1'b0;
		end else if (smp_rise) begin
			per_cnt_q <= '0;
			seen_q <= 1'b1;
			locked_q <= seen_q; // RULE7
			lost_q <= 1'b0;
		end else if (per_timeout) begin
			seen_q <= 1'b0;
			locked_q <= 1'b0;
			lost_q <= 1'b1;
		end else begin
			per_cnt_q <= per_cnt_q + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// power sequencer
	aserc_pwr_t pwr_q, pwr_d;
	logic [8:0] wake_q, wake_d;
	logic part_req, full_req, mute, clk_stop_q;

	// unassigned, the pin only mutes the lanes
	assign part_req = pin_s2_q && ctrl.pin_partial; // RULE5
	assign mute = pin_s2_q && !ctrl.pin_partial;
	assign full_req = ctrl.full_pd;

	always_comb begin
		pwr_d = pwr_q;
		wake_d = wake_q;
		unique case (pwr_q)
			ASERC_PWR_ON: begin
				if (full_req) begin
					pwr_d = ASERC_PWR_FULL_PD;
				end else if (part_req) begin
					pwr_d = ASERC_PWR_PART_PD;
				end
			end
			ASERC_PWR_FULL_PD: begin
				if (!full_req) begin
					pwr_d = ASERC_PWR_WAKE;
					// state step and awake flop use two cycles of the budget
					wake_d = 9'(`ASERC_WAKE_FULL_CYC - 2); // RULE3
				end
			end
			ASERC_PWR_PART_PD: begin
				if (full_req) begin
					pwr_d = ASERC_PWR_FULL_PD;
				end else if (!part_req) begin
					pwr_d = ASERC_PWR_WAKE;
					// short wake only if the clock stayed alive
					// pin sync, state step and awake flop use four cycles
					wake_d = clk_stop_q ? 9'(`ASERC_WAKE_FULL_CYC - 4) :
						9'(`ASERC_WAKE_PART_CYC - 4); // RULE4
				end
			end
			ASERC_PWR_WAKE: begin
				if (full_req) begin
					pwr_d = ASERC_PWR_FULL_PD;
				end else if (part_req) begin
					pwr_d = ASERC_PWR_PART_PD;
				end else if (wake_q == 9'h001) begin
					pwr_d = ASERC_PWR_ON; // RULE3 RULE4
				end else begin
					wake_d = wake_q - 9'h001;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pwr_q <= ASERC_PWR_ON;
			wake_q <= '0;
			clk_stop_q <= 1'b0;
		end else begin
			pwr_q <= pwr_d;
			wake_q <= wake_d;
			// remember a stalled clock for the whole partial sleep
			if (pwr_q != ASERC_PWR_PART_PD) begin
				clk_stop_q <= 1'b0;
			end else if (per_timeout) begin
				clk_stop_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// capture: one shared edge latches every channel together
	aserc_words_t hold_q;
	logic pend_q;

	for (genvar c = 0; c < `ASERC_NCH; c++) begin : g_cap
		always_ff @(posedge clk_sys_i) begin
			if (srst_i) begin
				hold_q[c] <= '0;
			end else if (smp_rise) begin
				// msb flip turns offset binary into twos complement
				hold_q[c] <= conv_data_i[c] ^
					{ctrl.twos_complement_select, 11'h000}; // RULE9 RULE14
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// frame sequencer: two system cycles per bit, 24 per frame; a
	// sample arriving mid-frame waits, newer ones overwrite it
	logic [4:0] ph_q, ph_d;
	logic run_q, run_d;
	logic go, start, shift, frame_end;

	assign go = locked_q && pwr_q == ASERC_PWR_ON && !mute;
	assign frame_end = run_q && ph_q == 5'(`ASERC_FRAME_CYC - 1);
	assign start = go && (smp_rise || pend_q) && (!run_q || frame_end);
	// a started frame always finishes, so the receiver never sees a stub
	assign run_d = start || (run_q && !frame_end);
	assign ph_d = start ? 5'h00 : (run_d ? ph_q + 5'h01 : 5'h00);
	assign shift = run_d && !start && !ph_d[0];

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ph_q <= '0;
			run_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			ph_q <= ph_d;
			run_q <= run_d;
			// the load wins over a sample arriving in the same cycle; pend_q clears
			pend_q <= go && (smp_rise ? run_q && !frame_end : pend_q && !start);
		end
	end

	aserc_serializer u_ser (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.load_i(start),
		.shift_i(shift),
		.clear_i(!run_d),
		.msb_first_i(ctrl.msb_first),
		.words_i(hold_q),
		.serial_o(serial_data_o)
	);

	////////////////////////////////////////////////////////////////////
	// link clocks registered in step with the lane data
	logic bclk_d, fclk_d;

	// ddr toggles mid-bit, sdr rises mid-bit once per bit
	assign bclk_d = run_d && (ctrl.single_rate_select ? ph_d[0] :
		ph_d[1] ^ ph_d[0]); // RULE8 RULE15
	assign fclk_d = run_d && ph_d < 5'(`ASERC_FRAME_CYC / 2); // RULE8 RULE16

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			bit_clock_out_o <= 1'b0;
			frame_clock_out_o <= 1'b0;
		end else begin
			bit_clock_out_o <= bclk_d;
			frame_clock_out_o <= fclk_d; // RULE1
		end
	end

	////////////////////////////////////////////////////////////////////
	// analog settings and power levels
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			pga_gain_o <= ASERC_PGA_20DB;
			lpf_corner_o <= ASERC_LPF_10MHZ;
			clamp_level_o <= '0;
			power_full_o <= 1'b0;
			power_part_o <= 1'b0;
			awake_o <= 1'b0;
		end else begin
			pga_gain_o <= ctrl.pga_gain; // RULE10
			lpf_corner_o <= ctrl.lpf_corner; // RULE11
			clamp_level_o <= ctrl.clamp_level; // RULE12
			power_full_o <= pwr_q == ASERC_PWR_FULL_PD;
			power_part_o <= pwr_q == ASERC_PWR_PART_PD;
			awake_o <= pwr_q == ASERC_PWR_ON;
		end
	end

	// cw matrix: nibble per channel picks one of ten columns, else open
	for (genvar c = 0; c < `ASERC_NCH; c++) begin : g_cw
		for (genvar k = 0; k < `ASERC_NCOL; k++) begin : g_col
			always_ff @(posedge clk_sys_i) begin
				if (srst_i) begin
					cw_switch_o[c*`ASERC_NCOL+k] <= 1'b0;
				end else begin
					cw_switch_o[c*`ASERC_NCOL+k] <=
						cwsel[4*c+3:4*c] == 4'(k); // RULE13
				end
			end
		end
	end

	assign stat.awake = pwr_q == ASERC_PWR_ON;
	assign stat.pwr = pwr_q;
	assign stat.locked = locked_q;
	assign stat.clk_lost = lost_q;

endmodule : aserc_top

// ### test/aserc_chk.sv
`timescale 1ns/1ns

module aserc_chk (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic frame_clock_out_o,
	input wire logic bit_clock_out_o,
	input wire logic power_full_o,
	input wire logic power_part_o,
	input wire logic awake_o
);
	logic [4:0] lo_cnt_q;
	logic [4:0] lo_cnt_d;

	////////////////////////////////////////////////////////////////////////
	// low-phase length; saturates so long idle never wraps into a short gap
	assign lo_cnt_d = frame_clock_out_o ? 5'h00 :
		(lo_cnt_q == 5'h1f ? lo_cnt_q : lo_cnt_q + 5'h01);
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			lo_cnt_q <= 5'h1f;
		end else begin
			lo_cnt_q <= lo_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	AST_FCLK_HIGH: assert property ($rose(frame_clock_out_o) |->
		frame_clock_out_o[*8] ##1 frame_clock_out_o[*4] ##1 !frame_clock_out_o)
		else $error("frame clock high phase not 12 cycles");
	AST_FCLK_LOW: assert property ($rose(frame_clock_out_o) |->
		lo_cnt_q >= 5'h0c) else $error("frame clock low phase short");
	AST_BCLK_PHASE: assert property ($rose(frame_clock_out_o) |->
		!bit_clock_out_o ##1 bit_clock_out_o) else $error("bit clock phase");
	AST_FRAME_AWAKE: assert property ($rose(frame_clock_out_o) |->
		awake_o) else $error("frame started while asleep");
	AST_FULL_ASLEEP: assert property (power_full_o |->
		!awake_o && !power_part_o) else $error("awake in full power-down");
	AST_FULL_WAKE: assert property ($fell(power_full_o) |->
		##[0:500] awake_o) else $error("full wake too slow");
	AST_PART_ASLEEP: assert property ($rose(power_part_o) |->
		!awake_o) else $error("awake in partial power-down");
	AST_AXI_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	AST_AXI_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	AST_AXI_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");

	cover property ($rose(frame_clock_out_o));
	cover property ($fell(power_full_o));
	cover property ($fell(power_part_o));
endmodule : aserc_chk

bind aserc_top aserc_chk aserc_chk_inst (
	.clk_sys_i(clk_sys_i), .srst_i(srst_i),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.frame_clock_out_o(frame_clock_out_o),
	.bit_clock_out_o(bit_clock_out_o), .power_full_o(power_full_o),
	.power_part_o(power_part_o), .awake_o(awake_o)
);

// ### test/aserc_rx_model.sv
`timescale 1ns/1ns

module aserc_rx_model
	import aserc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic sdr_i,
	input wire logic [7:0] serial_data_i,
	input wire logic bit_clock_out_i,
	input wire logic frame_clock_out_i,
	output aserc_words_t rx_words_o,
	output logic [7:0] rx_count_o
);
	logic bclk_q;
	logic fclk_q;
	logic [3:0] idx_q;
	logic take;

	// ddr uses both edges, sdr only the rising one
	assign take = sdr_i ? (bit_clock_out_i && !bclk_q) :
		(bit_clock_out_i != bclk_q);

	// first bit after frame rise lands in slot 0
	always_ff @(posedge clk_sys_i) begin
		bclk_q <= bit_clock_out_i;
		fclk_q <= frame_clock_out_i;
		if (srst_i) begin
			idx_q <= 4'hc;
			rx_count_o <= 8'h00;
		end else if (frame_clock_out_i && !fclk_q) begin
			idx_q <= 4'h0;
		end else if (take && idx_q < 4'hc) begin
			for (int c = 0; c < 8; c++) begin
				rx_words_o[c][idx_q] <= serial_data_i[c];
			end
			idx_q <= idx_q + 4'h1;
			if (idx_q == 4'hb) begin
				rx_count_o <= rx_count_o + 8'h01;
			end
		end
	end
endmodule : aserc_rx_model

// ### test/adc_serial_output_and_power_control_bench.sv
`timescale 1ns/1ns
`include "aserc_consts.svh"

module adc_serial_output_and_power_control_bench
	import aserc_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, sclk = 1'b0, slp = 1'b0, sdr = 1'b0;
	logic [3:0] awa = 4'h0, ara = 4'h0, wst = 4'hf;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic awr, wr, bv, arr, rv, bck, fck, pfull, ppart, awk;
	logic [1:0] brs, rrs;
	logic [31:0] rd;
	logic [7:0] ser, rxn;
	logic [2:0] clamp;
	logic [79:0] cw;
	aserc_words_t conv = '0, rxw;
	aserc_pga_t pga;
	aserc_lpf_t lpf;
	int miscompares = 0, total_checks = 0;

	always #50 clk = ~clk;
	// sample clock never stops, so partial wake stays short
	initial #37 forever #400 sclk = ~sclk;

	aserc_top aserc_top_inst (.clk_sys_i(clk), .srst_i(rst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(brs), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rrs),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .sample_clock_in_i(sclk),
		.converter_sleep_pin_i(slp), .conv_data_i(conv),
		.serial_data_o(ser), .bit_clock_out_o(bck),
		.frame_clock_out_o(fck), .pga_gain_o(pga), .lpf_corner_o(lpf),
		.clamp_level_o(clamp), .cw_switch_o(cw), .power_full_o(pfull),
		.power_part_o(ppart), .awake_o(awk));

	aserc_rx_model aserc_rx_model_inst (.clk_sys_i(clk), .srst_i(rst),
		.sdr_i(sdr), .serial_data_i(ser), .bit_clock_out_i(bck),
		.frame_clock_out_i(fck), .rx_words_o(rxw), .rx_count_o(rxn));

	////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// handshakes judged mid-cycle, taken at the following rising edge
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ha, hw, hb;
		int n;
		n = 0;
		hb = 1'b0;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!hb && n < 60) begin
			@(negedge clk);
			ha = awv && awr;
			hw = wv && wr;
			hb = bv;
			r = brs;
			@(posedge clk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
			n++;
		end
		bry <= 1'b0;
		chk({31'h0, hb}, 32'h1);
	endtask : axw

	task automatic axr(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ha, hr;
		int n;
		n = 0;
		hr = 1'b0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		while (!hr && n < 60) begin
			@(negedge clk);
			ha = arv && arr;
			hr = rv;
			d = rd;
			r = rrs;
			@(posedge clk);
			if (ha) arv <= 1'b0;
			n++;
		end
		rry <= 1'b0;
		chk({31'h0, hr}, 32'h1);
	endtask : axr

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axr(`ASERC_OFS_CTRL, d, r);
		chk(d, 32'h0);
		axr(`ASERC_OFS_CWSEL, d, r);
		chk(d, `ASERC_CWSEL_RST);
		chk({31'h0, |cw}, 32'h0);
		axr(4'hc, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, `ASERC_RESP_SLVERR});
		axw(`ASERC_OFS_STAT, 32'h1f, r);
		chk({30'h0, r}, {30'h0, `ASERC_RESP_SLVERR});
	endtask : t_regs

	task automatic t_analog;
		logic [31:0] d, q;
		logic [1:0] r;
		for (int g = 0; g < 4; g++) begin
			d = (32'(g) << 5) | (32'(g & 1) << 7) | (32'(7 - g) << 8);
			axw(`ASERC_OFS_CTRL, d, r);
			// outputs are flopped from the register, let them settle
			@(negedge clk);
			chk({30'h0, pga}, g);
			chk({31'h0, lpf}, g & 1);
			chk({29'h0, clamp}, 7 - g);
			axr(`ASERC_OFS_CTRL, q, r);
			chk(q, d);
		end
	endtask : t_analog

	task automatic t_cw;
		logic [31:0] v;
		logic [95:0] e, g;
		logic [1:0] r;
		v = 32'hf9a0_5c31;
		e = '0;
		for (int c = 0; c < 8; c++) begin
			if (v[c*4+:4] < 4'ha) e[c*10+v[c*4+:4]] = 1'b1;
		end
		axw(`ASERC_OFS_CWSEL, v, r);
		@(negedge clk);
		g = {16'h0, cw};
		for (int i = 0; i < 3; i++) chk(g[i*32+:32], e[i*32+:32]);
	endtask : t_cw

	// third frame after the change is wholly in the new mode
	task automatic t_frame(input logic m, input logic t, input logic s);
		logic [1:0] r;
		logic [11:0] e;
		logic [7:0] n0;
		int k;
		for (int c = 0; c < 8; c++) conv[c] <= 12'(12'h3a6 + 12'h150 * c);
		sdr <= s;
		axw(`ASERC_OFS_CTRL, {29'h0, s, t, m}, r);
		n0 = rxn;
		k = 0;
		while (8'(rxn - n0) < 8'h03 && k < 400) begin
			@(posedge clk);
			k++;
		end
		chk(32'(k < 400), 32'h1);
		for (int c = 0; c < 8; c++) begin
			e = conv[c] ^ (t ? 12'h800 : 12'h000);
			if (m) e = {<<{e}};
			chk({20'h0, rxw[c]}, {20'h0, e});
		end
	endtask : t_frame

	task automatic t_wait_awake(input int lim);
		int k;
		k = 0;
		while (awk !== 1'b1 && k < 600) begin
			@(posedge clk);
			k++;
		end
		chk(32'(k <= lim), 32'h1);
	endtask : t_wait_awake

	task automatic t_power;
		logic [1:0] r;
		axw(`ASERC_OFS_CTRL, 32'h10, r);
		repeat (2) @(posedge clk);
		chk({30'h0, pfull, awk}, 32'h2);
		axw(`ASERC_OFS_CTRL, 32'h0, r);
		t_wait_awake(500);
		slp <= 1'b1;
		repeat (8) @(posedge clk);
		chk({31'h0, ppart}, 32'h0);
		slp <= 1'b0;
		axw(`ASERC_OFS_CTRL, 32'h8, r);
		slp <= 1'b1;
		repeat (8) @(posedge clk);
		chk({30'h0, ppart, awk}, 32'h2);
		slp <= 1'b0;
		// 20 cycles including the pin synchroniser, three of margin
		t_wait_awake(23);
	endtask : t_power

	////////////////////////////////////////////////////////////////////////
	initial begin
		#3000000;
		miscompares++;
		test_done;
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_analog;
		t_cw;
		t_frame(1'b0, 1'b0, 1'b0);
		t_frame(1'b1, 1'b1, 1'b0);
		t_frame(1'b0, 1'b0, 1'b1);
		t_frame(1'b1, 1'b0, 1'b1);
		t_power;
		test_done;
	end
endmodule : adc_serial_output_and_power_control_bench
